// *** inc/rpo_cfg.svh ***
// Register offsets, reset values and timing counts of the rail output block
`ifndef RPO_CFG_SVH
`define RPO_CFG_SVH
`define RPO_A_RAILEN 8'h00
`define RPO_A_DRV 8'h04
`define RPO_A_GPO 8'h08
`define RPO_A_PG 8'h0c
`define RPO_A_SEQ 8'h10
`define RPO_A_PWMSEL 8'h14
`define RPO_A_FDIV 8'h18
`define RPO_A_FDUTY 8'h28
`define RPO_A_SDUTY 8'h48
`define RPO_A_SDIV 8'h58
`define RPO_A_MRG 8'h60
`define RPO_A_MTGT 8'h64
`define RPO_A_MNOM 8'h68
`define RPO_A_FAN 8'h6c
`define RPO_A_STAT 8'h70
`define RPO_A_FCNT 8'h74
`define RPO_A_CAL 8'h7c
`define RPO_MAX_EN 5'h0a
`define RPO_FDIV_MIN 14'h0002
`define RPO_SDIV_MIN 24'h000002
`define RPO_PHASE_MAX 9'h167
`define RPO_DEG_FULL 23'h000168
`define RPO_SLOW_INC 6'h05
`define RPO_STAT_REFUSED 13
`define RPO_CLK_HZ 100000000
`define RPO_SLOW1_HZ 10000
`define RPO_SLOW2_HZ 1000
`define RPO_FAN_WIN_S 1
`define RPO_SLOW1_CYC (`RPO_CLK_HZ / `RPO_SLOW1_HZ)
`define RPO_SLOW2_CYC (`RPO_CLK_HZ / `RPO_SLOW2_HZ)
`define RPO_FAN_WIN_CYC (`RPO_CLK_HZ * `RPO_FAN_WIN_S)
`endif

// *** inc/rpo_pkg.sv ***
// Types of the rail output block
`default_nettype none
package rpo_pkg;
  typedef enum logic [3:0] {
    SEQ_OFF = 4'h1,
    SEQ_UP = 4'h2,
    SEQ_ON = 4'h4,
    SEQ_DOWN = 4'h8
  } rpo_seq_type;
  typedef enum logic [1:0] {
    MRG_DISABLE = 2'h0,
    MRG_TRISTATE = 2'h1,
    MRG_TRIM = 2'h2,
    MRG_FIXED = 2'h3
  } rpo_mrg_type;
endpackage : rpo_pkg
`default_nettype wire

// *** logic/rpo_top.sv ***
// Rail enables, cascade, fast and slow pulse outputs, margining and fan tach
// Function
// - Rail enable pins select active level and open-drain or push-pull drive.
// - In reset plain pins float, fast-pulse-capable pins are driven low.
// - At most ten pins may be rail enables at once.
// - A cascade slave starts only after the master reports all rails good.
// - Starting power-down drops the cascade output at once.
// - Power-good output reflects a chosen subset of rail good states.
// - Fast output period is an integer divisor from 2 to 16383.
// - Fast outputs share divisors in pairs one-two through seven-eight.
// - Selecting one fast output enables its free pair companion too.
// - A fast pin not pulsing works as a general pin.
// - Fast duty resolves in sixteenths of a source clock.
// - First slow output runs at 10 kHz, second at 1 kHz.
// - Slow outputs three and four divide 15.625 MHz by 2 to 2^24-1.
// - Adjustable slow duty step is one 15.625 MHz tick.
// - Each fast output has its own phase offset of 0 to 359 degrees.
// - Margining commanded by register bits or by enable and direction pins.
// - Open-loop margining drives two open-drain outputs up or down.
// - Closed-loop margining steps duty until the rail meets its target.
// - Outside margining the margin output follows its selected mode.
// - Tach pulses per window checked against threshold times pulses per rev.
// - Autocalibration runs on enable and after reset if stored enabled.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rpo_cfg.svh"
module rpo_top #(
  parameter int SLOW1_CYC = `RPO_SLOW1_CYC,
  parameter int SLOW2_CYC = `RPO_SLOW2_CYC,
  parameter int FAN_WIN_CYC = `RPO_FAN_WIN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [9:0] railGood,
  input wire logic [11:0] measVolt,
  input wire logic measValid,
  input wire logic cascadeIn,
  input wire logic marginEnPin,
  input wire logic marginUpPin,
  input wire logic autocalStored,
  input wire logic [3:0] tachIn,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe,
  output logic [3:0] slowOut,
  output logic [3:0] slowOe,
  output logic pgOut,
  output logic marginUpOe,
  output logic marginDnOe,
  output rpo_pkg::rpo_seq_type seqState
);
  import rpo_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [4:0] ones(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int b = 0; b < 16; b++) begin
      c = c + {4'h0, v[b]};
    end
    return c;
  endfunction : ones

  function automatic logic [13:0] offCalc(input logic [13:0] d,
      input logic [8:0] p);
    logic [22:0] m;
    m = {9'h000, d} * {14'h0000, p};
    m = m / `RPO_DEG_FULL;
    return m[13:0];
  endfunction : offCalc

  // Three-stage synchronisers; a change is taken once stages two and three agree
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;
  assign asyncIn = {autocalStored, tachIn, marginUpPin, marginEnPin,
                    cascadeIn};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end
  logic casIn, mEnPin, mUpPin, calStrap;
  logic [3:0] tach;
  assign casIn = filt_q[0];
  assign mEnPin = filt_q[1];
  assign mUpPin = filt_q[2];
  assign tach = filt_q[6:3];
  assign calStrap = filt_q[7];

  // Register file
  logic [15:0] railEn_q, pol_q, od_q, gpoLvl_q, gpoSel_q;
  logic [9:0] pgMask_q;
  logic seqStart_q, seqSlave_q, refused_q;
  logic [7:0] fSel_q;
  logic [3:0] sSel_q;
  logic [13:0] fDiv_q [4];
  logic [17:0] fDuty_q [8];
  logic [8:0] fPhase_q [8];
  logic [23:0] sDuty_q [4];
  logic [23:0] sDiv_q [2];
  logic [31:0] mrg_q, mTgt_q, fan_q;
  logic [11:0] mNom_q;
  logic wbHit, wbWr;
  logic [31:0] rdMux;
  logic [31:0] wv;
  // Unselected bytes keep their old contents
  assign wv = merge(rdMux, wb_dat_i, wb_sel_i);
  assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr = wbHit & wb_we_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      railEn_q <= '0;
      pol_q <= '0;
      od_q <= '0;
      gpoLvl_q <= '0;
      gpoSel_q <= '0;
      pgMask_q <= '0;
      seqStart_q <= 1'b0;
      seqSlave_q <= 1'b0;
      fSel_q <= '0;
      sSel_q <= '0;
      mrg_q <= '0;
      mTgt_q <= '0;
      mNom_q <= '0;
      fan_q <= '0;
      for (int i = 0; i < 4; i++) begin
        fDiv_q[i] <= `RPO_FDIV_MIN;
        sDuty_q[i] <= '0;
      end
      for (int i = 0; i < 8; i++) begin
        fDuty_q[i] <= '0;
        fPhase_q[i] <= '0;
      end
      for (int i = 0; i < 2; i++) begin
        sDiv_q[i] <= `RPO_SDIV_MIN;
      end
    end else if (wbWr) begin
      case (wb_adr_i & 8'hfc)
        `RPO_A_RAILEN: if (ones(wv[15:0]) <= `RPO_MAX_EN) railEn_q <= wv[15:0];
        `RPO_A_DRV: begin
          pol_q <= wv[15:0];
          od_q <= wv[31:16];
        end
        `RPO_A_GPO: begin
          gpoLvl_q <= wv[15:0];
          gpoSel_q <= wv[31:16];
        end
        `RPO_A_PG: pgMask_q <= wv[9:0];
        `RPO_A_SEQ: begin
          seqStart_q <= wv[0];
          seqSlave_q <= wv[1];
        end
        `RPO_A_PWMSEL: begin
          fSel_q <= wv[7:0];
          sSel_q <= wv[11:8];
        end
        `RPO_A_MRG: mrg_q <= wv;
        `RPO_A_MTGT: mTgt_q <= wv;
        `RPO_A_MNOM: mNom_q <= wv[11:0];
        `RPO_A_FAN: fan_q <= wv;
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if ((wb_adr_i & 8'hfc) == `RPO_A_FDIV + 8'(4*i)) begin
          fDiv_q[i] <= (wv[13:0] < `RPO_FDIV_MIN) ? `RPO_FDIV_MIN : wv[13:0];
        end
        if ((wb_adr_i & 8'hfc) == `RPO_A_SDUTY + 8'(4*i)) begin
          sDuty_q[i] <= wv[23:0];
        end
      end
      for (int i = 0; i < 8; i++) begin
        if ((wb_adr_i & 8'hfc) == `RPO_A_FDUTY + 8'(4*i)) begin
          fDuty_q[i] <= wv[17:0];
          fPhase_q[i] <= (wv[28:20] > `RPO_PHASE_MAX) ? `RPO_PHASE_MAX : wv[28:20];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if ((wb_adr_i & 8'hfc) == `RPO_A_SDIV + 8'(4*i)) begin
          sDiv_q[i] <= (wv[23:0] < `RPO_SDIV_MIN) ? `RPO_SDIV_MIN : wv[23:0];
        end
      end
    end
  end

  // Refused enable writes leave a sticky flag; a new refusal beats a clear
  logic refuseNow;
  assign refuseNow = wbWr & ((wb_adr_i & 8'hfc) == `RPO_A_RAILEN)
      & (ones(wv[15:0]) > `RPO_MAX_EN);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else if (refuseNow) begin
      refused_q <= 1'b1;
    end else if (wbWr && (wb_adr_i & 8'hfc) == `RPO_A_STAT
                 && wb_dat_i[`RPO_STAT_REFUSED] && wb_sel_i[1]) begin
      refused_q <= 1'b0;
    end
  end

  // Sequencer and cascade
  logic grpGood, grpAny;
  assign grpGood = &(railGood | ~pgMask_q);
  assign grpAny = |(railGood & pgMask_q);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seqState <= SEQ_OFF;
    end else begin
      unique case (seqState)
        SEQ_OFF: if (seqStart_q && (!seqSlave_q || casIn)) seqState <= SEQ_UP;
        SEQ_UP: begin
          if (!seqStart_q || (seqSlave_q && !casIn)) seqState <= SEQ_DOWN;
          else if (grpGood) seqState <= SEQ_ON;
        end
        SEQ_ON: begin
          // A lost rail of the power-good subset counts as a fault and starts power-down
          if (!seqStart_q || !grpGood || (seqSlave_q && !casIn)) begin
            seqState <= SEQ_DOWN;
          end
        end
        SEQ_DOWN: if (!grpAny) seqState <= SEQ_OFF;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgOut <= 1'b0;
    end else begin
      pgOut <= (seqState == SEQ_ON) && grpGood && seqStart_q;
    end
  end

  // Margining command and closed-loop trim
  logic mgOn, mgUp, clActive;
  logic [2:0] mChan;
  logic [17:0] mDuty_q;
  logic [11:0] mTarget;
  rpo_mrg_type mMode;
  assign mMode = rpo_mrg_type'(mrg_q[5:4]);
  assign mChan = mrg_q[10:8];
  assign mgOn = (mrg_q[2] ? mEnPin : mrg_q[0]) && mMode != MRG_DISABLE;
  assign mgUp = mrg_q[2] ? mUpPin : mrg_q[1];
  assign clActive = mgOn || mMode == MRG_TRIM;
  assign mTarget = !mgOn ? mNom_q : (mgUp ? mTgt_q[27:16] : mTgt_q[11:0]);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mDuty_q <= '0;
    end else if (!clActive) begin
      mDuty_q <= fDuty_q[mChan];
    end else if (measValid) begin
      // A higher duty raises the margin node; the loop steps once per sample
      if (measVolt < mTarget && mDuty_q != 18'h3ffff) mDuty_q <= mDuty_q + 18'h00001;
      else if (measVolt > mTarget && mDuty_q != 18'h00000) mDuty_q <= mDuty_q - 18'h00001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      marginUpOe <= 1'b0;
      marginDnOe <= 1'b0;
    end else begin
      marginUpOe <= mgOn && mgUp;
      marginDnOe <= mgOn && !mgUp;
    end
  end

  // Fast outputs: one counter per pair, duty in sixteenths of a cycle
  logic [7:0] fEff, fWave;
  logic [13:0] pCnt_q [4];
  logic [13:0] pDiv_q [4];
  logic [17:0] aDuty_q [8];
  logic [13:0] aOff_q [8];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gFast
      localparam int C = g ^ 1;
      localparam int P = g / 2;
      logic [14:0] pos;
      logic [13:0] ph;
      assign fEff[g] = fSel_q[g] | (fSel_q[C] & ~railEn_q[g] & ~gpoSel_q[g]);
      assign pos = {1'b0, pCnt_q[P]} + {1'b0, aOff_q[g]};
      assign ph = (pos >= {1'b0, pDiv_q[P]}) ? 14'(pos - {1'b0, pDiv_q[P]}) : pos[13:0];
      assign fWave[g] = {ph, 4'h0} < aDuty_q[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          aDuty_q[g] <= '0;
          aOff_q[g] <= '0;
        end else if (pCnt_q[P] == pDiv_q[P] - 14'h0001) begin
          aDuty_q[g] <= (clActive && mChan == 3'(g)) ? mDuty_q : fDuty_q[g];
          aOff_q[g] <= offCalc(fDiv_q[P], fPhase_q[g]);
        end
      end
    end
    for (g = 0; g < 4; g++) begin : gPair
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pCnt_q[g] <= '0;
          pDiv_q[g] <= `RPO_FDIV_MIN;
        end else if (pCnt_q[g] >= pDiv_q[g] - 14'h0001) begin
          pCnt_q[g] <= '0;
          pDiv_q[g] <= fDiv_q[g];
        end else begin
          pCnt_q[g] <= pCnt_q[g] + 14'h0001;
        end
      end
    end
    // General pin drivers
    for (g = 0; g < 16; g++) begin : gPin
      logic lvl, isPwm;
      assign isPwm = (g < 8) ? fEff[g % 8] : 1'b0;
      assign lvl = railEn_q[g] ? (seqState == SEQ_UP || seqState == SEQ_ON)
                               : gpoLvl_q[g];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pinOut[g] <= 1'b0;
          pinOe[g] <= (g < 8);
        end else if (isPwm) begin
          pinOut[g] <= fWave[g % 8];
          pinOe[g] <= !(mMode == MRG_TRISTATE && !mgOn && mChan == 3'(g));
        end else if (railEn_q[g] || gpoSel_q[g]) begin
          pinOut[g] <= od_q[g] ? 1'b0 : (lvl ^ ~pol_q[g]);
          pinOe[g] <= od_q[g] ? !(lvl ^ ~pol_q[g]) : 1'b1;
        end else begin
          pinOut[g] <= 1'b0;
          pinOe[g] <= (g < 8);
        end
      end
    end
  endgenerate

  // Slow outputs; the 15.625 MHz tick is 5/32 of the 100 MHz clock
  logic [4:0] tAcc_q;
  logic [5:0] tSum;
  logic [23:0] sCnt_q [4];
  logic [23:0] sPer [4];
  logic [23:0] sPerA_q [2];
  assign tSum = {1'b0, tAcc_q} + `RPO_SLOW_INC;
  assign sPer[0] = 24'(SLOW1_CYC);
  assign sPer[1] = 24'(SLOW2_CYC);
  assign sPer[2] = sPerA_q[0];
  assign sPer[3] = sPerA_q[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tAcc_q <= '0;
    end else begin
      tAcc_q <= tSum[4:0];
    end
  end
  generate
    for (g = 0; g < 4; g++) begin : gSlow
      logic step;
      assign step = (g < 2) ? 1'b1 : tSum[5];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sCnt_q[g] <= '0;
        end else if (step) begin
          sCnt_q[g] <= (sCnt_q[g] >= sPer[g] - 24'h000001) ? '0 : sCnt_q[g] + 24'h000001;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          slowOut[g] <= 1'b0;
          slowOe[g] <= 1'b0;
        end else begin
          slowOut[g] <= sSel_q[g] && sCnt_q[g] < sDuty_q[g];
          slowOe[g] <= sSel_q[g];
        end
      end
    end
    for (g = 0; g < 2; g++) begin : gSlowDiv
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sPerA_q[g] <= `RPO_SDIV_MIN;
        end else if (sCnt_q[g+2] >= sPerA_q[g] - 24'h000001 && tSum[5]) begin
          sPerA_q[g] <= sDiv_q[g];
        end
      end
    end
  endgenerate

  // Fan tach windows, alarms and autocalibration
  logic [31:0] win_q;
  logic winEnd, calBusy_q, calEn_q, strapDone_q;
  logic [3:0] tachPrev_q, alarm_q;
  logic [15:0] tCnt_q [4];
  logic [15:0] tLast_q [4];
  logic [7:0] cal_q [4];
  assign winEnd = win_q == 32'(FAN_WIN_CYC - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_q <= '0;
      tachPrev_q <= '0;
    end else begin
      win_q <= winEnd ? '0 : win_q + 32'h00000001;
      tachPrev_q <= tach;
    end
  end
  generate
    for (g = 0; g < 4; g++) begin : gFan
      logic [19:0] need;
      assign need = {4'h0, fan_q[19:4]} * {16'h0000, fan_q[3:0]};
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tCnt_q[g] <= '0;
          tLast_q[g] <= '0;
          alarm_q[g] <= 1'b0;
          cal_q[g] <= '0;
        end else if (winEnd) begin
          tCnt_q[g] <= '0;
          tLast_q[g] <= tCnt_q[g];
          alarm_q[g] <= !sSel_q[g] && {4'h0, tCnt_q[g]} < need;
          if (calBusy_q) cal_q[g] <= (tCnt_q[g] > 16'h00ff) ? 8'hff : tCnt_q[g][7:0];
        end else if (tach[g] && !tachPrev_q[g] && tCnt_q[g] != 16'hffff) begin
          tCnt_q[g] <= tCnt_q[g] + 16'h0001;
        end
      end
    end
  endgenerate
  // The stored enable is caught after reset release, never inside the reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      calEn_q <= 1'b0;
      strapDone_q <= 1'b0;
      calBusy_q <= 1'b0;
    end else begin
      calEn_q <= fan_q[31];
      strapDone_q <= strapDone_q | (win_q == 32'h00000008);
      if ((fan_q[31] && !calEn_q) || (!strapDone_q && win_q == 32'h00000008 && calStrap)) begin
        calBusy_q <= 1'b1;
      end else if (winEnd) begin
        calBusy_q <= 1'b0;
      end
    end
  end

  // Bus read mux and answer
  always_comb begin
    rdMux = 32'h00000000;
    case (wb_adr_i & 8'hfc)
      `RPO_A_RAILEN: rdMux = {16'h0000, railEn_q};
      `RPO_A_DRV: rdMux = {od_q, pol_q};
      `RPO_A_GPO: rdMux = {gpoSel_q, gpoLvl_q};
      `RPO_A_PG: rdMux = {22'h000000, pgMask_q};
      `RPO_A_SEQ: rdMux = {30'h00000000, seqSlave_q, seqStart_q};
      `RPO_A_PWMSEL: rdMux = {20'h00000, sSel_q, fSel_q};
      `RPO_A_MRG: rdMux = mrg_q;
      `RPO_A_MTGT: rdMux = mTgt_q;
      `RPO_A_MNOM: rdMux = {20'h00000, mNom_q};
      `RPO_A_FAN: rdMux = fan_q;
      `RPO_A_STAT: rdMux = {18'h00000, refused_q, calBusy_q, alarm_q,
                            3'h0, pgOut, seqState};
      `RPO_A_FCNT: rdMux = {tLast_q[1], tLast_q[0]};
      `RPO_A_FCNT + 8'h04: rdMux = {tLast_q[3], tLast_q[2]};
      `RPO_A_CAL: rdMux = {cal_q[3], cal_q[2], cal_q[1], cal_q[0]};
      default: rdMux = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if ((wb_adr_i & 8'hfc) == `RPO_A_FDIV + 8'(4*i)) rdMux = {18'h00000, fDiv_q[i]};
      if ((wb_adr_i & 8'hfc) == `RPO_A_SDUTY + 8'(4*i)) rdMux = {8'h00, sDuty_q[i]};
    end
    for (int i = 0; i < 8; i++) begin
      if ((wb_adr_i & 8'hfc) == `RPO_A_FDUTY + 8'(4*i)) begin
        rdMux = {3'h0, fPhase_q[i], 2'h0, fDuty_q[i]};
      end
    end
    for (int i = 0; i < 2; i++) begin
      if ((wb_adr_i & 8'hfc) == `RPO_A_SDIV + 8'(4*i)) rdMux = {8'h00, sDiv_q[i]};
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbHit;
      wb_dat_o <= wbHit ? rdMux : 32'h00000000;
    end
  end
endmodule : rpo_top
`default_nettype wire

// *** test/rpo_top_sva.sv ***
// Port assertions of the rail output block
`timescale 1ns/1ps
`default_nettype none
module rpo_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  input wire logic pgOut,
  input wire logic marginUpOe,
  input wire logic marginDnOe,
  input wire rpo_pkg::rpo_seq_type seqState
);
  import rpo_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackOnce;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_fixed_a: assert property (busReq |=> ackOnce)
    else $error("bus answer not a single cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  reset_pins_a: assert property ($fell(rst) |-> pinOe == 16'h00ff && pinOut == 16'h0000)
    else $error("pins not in reset state");
  seq_onehot_a: assert property ($onehot(seqState))
    else $error("sequence state not one-hot");
  seq_order_a: assert property ($changed(seqState) |-> seqState == SEQ_DOWN
    || (seqState == SEQ_UP && $past(seqState) == SEQ_OFF)
    || (seqState == SEQ_ON && $past(seqState) == SEQ_UP)
    || (seqState == SEQ_OFF && $past(seqState) == SEQ_DOWN))
    else $error("illegal sequence step");
  pg_needs_on_a: assert property (pgOut |-> $past(seqState) == SEQ_ON)
    else $error("power good outside on state");
  down_no_pg_a: assert property (seqState == SEQ_DOWN |=> !pgOut)
    else $error("power good held during power-down");
  margin_excl_a: assert property (!(marginUpOe && marginDnOe))
    else $error("both margin pins pulled");
endmodule : rpo_top_sva
bind rpo_top rpo_top_sva rpo_top_sva_inst (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .pinOut, .pinOe, .pgOut, .marginUpOe, .marginDnOe,
  .seqState);
`default_nettype wire

// *** test/rpo_supply_model.sv ***
// Supplies, fans and monitor feeding the rail output block
`timescale 1ns/1ps
`default_nettype none
module rpo_supply_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  output logic [9:0] railGood,
  output logic [3:0] tachIn,
  output logic [11:0] measVolt,
  output logic measValid
);
  logic [15:0][9:0] hist_q;
  logic [7:0] tick_q;
  // Enable lines have pull-downs, so a released pin reads as off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[14:0], 2'b00, pinOe[15:8] & pinOut[15:8]};
    end
  end
  // Rails come good slowly, sixteen cycles after the enable
  assign railGood = hist_q[15];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 8'h01;
    end
  end
  assign tachIn = {4{tick_q[5]}};
  assign measValid = tick_q[3:0] == 4'h0;
  assign measVolt = 12'h800;
endmodule : rpo_supply_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the rail output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rpo_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic cascadeIn = 1'b0;
  logic marginEnPin = 1'b0;
  logic marginUpPin = 1'b0;
  logic autocalStored = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pgOut, marginUpOe, marginDnOe, measValid;
  logic [15:0] pinOut, pinOe;
  logic [3:0] slowOut, slowOe, tachIn;
  logic [9:0] railGood;
  logic [11:0] measVolt;
  rpo_seq_type seqState;
  int bad_count = 0;
  int n_checks = 0;
  integer seed = 32'had408b34;
  logic [31:0] expQ [$];
  logic [31:0] monExp;
  logic [31:0] r;
  logic [8:0] ph;
  always #5 clk = ~clk;
  rpo_top #(.SLOW1_CYC(100), .SLOW2_CYC(200), .FAN_WIN_CYC(1000)) rpo_top_inst (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .railGood, .measVolt, .measValid,
    .cascadeIn, .marginEnPin, .marginUpPin, .autocalStored, .tachIn, .pinOut,
    .pinOe, .slowOut, .slowOe, .pgOut, .marginUpOe, .marginDnOe, .seqState);
  rpo_supply_model rpo_supply_model_inst (.clk, .rst, .pinOut, .pinOe,
    .railGood, .tachIn, .measVolt, .measValid);
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Request held until ack is seen at a falling edge, then released at the next rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(negedge clk); while (wb_ack_o !== 1'b1);
    @(posedge clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0) begin
      monExp = expQ.pop_front();
      check(wb_dat_o === monExp, "read data");
    end
  end
  function automatic logic bitOf(input int k);
    logic [19:0] v;
    v = {slowOut, pinOut};
    return v[k];
  endfunction : bitOf
  // Waits are left to the watchdog; a dead pin ends the run there
  task automatic period(input int k, input int per, input int hi);
    int n;
    int h;
    do @(negedge clk); while (bitOf(k) !== 1'b0);
    do @(negedge clk); while (bitOf(k) !== 1'b1);
    h = 0;
    do begin h++; @(negedge clk); end while (bitOf(k) === 1'b1);
    n = h;
    do begin n++; @(negedge clk); end while (bitOf(k) === 1'b0);
    check(n == per, "pulse period");
    if (hi >= 0) check(h == hi, "pulse width");
  endtask : period
  task automatic waitState(input rpo_seq_type s, input int lim);
    int n;
    n = 0;
    while (seqState !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(seqState === s, "sequence state");
  endtask : waitState
  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(pinOe === 16'h00ff && pinOut === 16'h0000, "reset pins");
    @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 32'h2);
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h2);
    wr(8'h18, 32'h3fff);
    rd(8'h18, 32'h3fff);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      ph = (i == 3) ? 9'h168 : r[28:20];
      wr(8'h28 + 8'(4 * i), {3'h0, ph, 2'h0, r[17:0]});
      rd(8'h28 + 8'(4 * i), {3'h0, (ph > 9'h167) ? 9'h167 : ph, 2'h0, r[17:0]});
    end
    $display("register test done");
    wr(8'h00, 32'h0700);
    wr(8'h00, 32'h07ff);
    rd(8'h00, 32'h0700);
    rd(8'h70, 32'h2001);
    wr(8'h70, 32'h2000);
    rd(8'h70, 32'h1);
    $display("enable limit test done");
    wr(8'h04, 32'h0400_0300);
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h3);
    repeat (20) @(negedge clk);
    check(seqState === SEQ_OFF, "slave waits for cascade");
    @(posedge clk);
    cascadeIn <= 1'b1;
    waitState(SEQ_ON, 100);
    check(pinOe[10:8] === 3'b111 && pinOut[10:8] === 3'b011, "enables");
    repeat (2) @(negedge clk);
    check(pgOut === 1'b1, "power good on subset");
    rd(8'h70, 32'h14);
    @(posedge clk);
    cascadeIn <= 1'b0;
    waitState(SEQ_DOWN, 20);
    @(negedge clk);
    check(pgOut === 1'b0, "cascade out dropped");
    waitState(SEQ_OFF, 100);
    check(pinOe[10] === 1'b0 && pinOut[9:8] === 2'b00, "enables off");
    wr(8'h10, 32'h0);
    $display("sequence test done");
    wr(8'h18, 32'h4);
    wr(8'h28, 32'h20);
    wr(8'h2c, 32'h10);
    wr(8'h08, 32'h0004_0004);
    wr(8'h48, 32'h32);
    wr(8'h4c, 32'h64);
    wr(8'h14, 32'h0000_0301);
    period(0, 4, 2);
    period(1, 4, 1);
    // Pin 2 is active low, so an asserted level drives it low
    check(pinOe[2] === 1'b1 && pinOut[2] === 1'b0, "general pin");
    check(slowOe === 4'h3, "slow select");
    wr(8'h18, 32'h6);
    period(0, 6, 2);
    period(16, 100, 50);
    period(17, 200, 100);
    $display("pulse test done");
    wr(8'h60, 32'h33);
    @(negedge clk);
    check(marginUpOe === 1'b1 && marginDnOe === 1'b0, "margin up");
    wr(8'h60, 32'h31);
    @(negedge clk);
    check(marginUpOe === 1'b0 && marginDnOe === 1'b1, "margin down");
    wr(8'h60, 32'h34);
    @(negedge clk);
    check(marginUpOe === 1'b0 && marginDnOe === 1'b0, "margin pin off");
    @(posedge clk);
    marginEnPin <= 1'b1;
    repeat (6) @(negedge clk);
    check(marginUpOe === 1'b0 && marginDnOe === 1'b1, "margin pins");
    $display("margin test done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
